/* include/adcoc_defs.svh */
// Register offsets, field positions, reset values and timing constants for the output config bank
`ifndef ADCOC_DEFS_SVH
`define ADCOC_DEFS_SVH

`define ADCOC_ADDR_W 8
`define ADCOC_OFF_TRIM 8'h10
`define ADCOC_OFF_OUT_MODE 8'h14
`define ADCOC_OFF_CLK_PHASE 8'h16
`define ADCOC_OFF_FINE_DELAY 8'h17
`define ADCOC_OFF_PAT1_LO 8'h19
`define ADCOC_OFF_PAT1_HI 8'h1a
`define ADCOC_OFF_PAT2_LO 8'h1b
`define ADCOC_OFF_PAT2_HI 8'h1c
`define ADCOC_OFF_SIG_LO 8'h24
`define ADCOC_OFF_FEATURE 8'h2a

`define ADCOC_RST_ZERO 8'h00
`define ADCOC_RST_FEATURE 8'h01

`define ADCOC_BIT_SWING 7
`define ADCOC_BIT_OTYPE 6
`define ADCOC_BIT_DCO_INV 7
`define ADCOC_BIT_OR_EN 0
`define ADCOC_PHASE_LSB 0
`define ADCOC_DDLY_LSB 4
`define ADCOC_CDLY_LSB 0

// Fine delay step in picoseconds and the largest tap code
`define ADCOC_DELAY_STEP_PS 290
`define ADCOC_TAP_MAX 3'h7

`endif

/* include/adcoc_pkg.sv */
// Types shared by the output config bank and its divider phase picker
package adcoc_pkg;

  typedef struct packed {
    logic swing_reduced;
    logic lvds_sel;
    logic dco_invert;
    logic [2:0] div_phase;
    logic [2:0] data_delay;
    logic [2:0] clock_delay;
    logic or_pin_en;
  } adcoc_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adcoc_req_t;

  typedef enum logic {
    ADCOC_IO_CMOS,
    ADCOC_IO_LVDS
  } adcoc_io_t;

endpackage

/* rtl/adcoc_phase_sel.sv */
// Picks the live divider tick or one of its seven delayed copies for the output clock
`timescale 1ns/100ps
`default_nettype none
module adcoc_phase_sel
  import adcoc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Divider tick and phase choice
  input wire logic div_tick,
  input wire logic div_active,
  input wire logic [2:0] phase,
  // Chosen tick
  output logic phase_tick
);

  logic [6:0] tap_r;
  logic [6:0] tap_nxt;

  // Shift line holds the tick delayed 1..7 input cycles; phase 0 takes the live tick
  always_comb begin
    tap_nxt = {tap_r[5:0], div_tick};
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tap_r <= 7'h00;
    end else begin
      tap_r <= tap_nxt;
    end
  end

  // Without division the phase choice has no meaning; raw tick passes
  always_comb begin
    if (div_active) begin
      phase_tick = (phase == 3'h0) ? div_tick : tap_r[phase - 3'h1];
    end else begin
      phase_tick = div_tick;
    end
  end

endmodule
`default_nettype wire

/* rtl/adcoc_regs.sv */
// Output configuration register bank with test pattern selection
`timescale 1ns/100ps
`default_nettype none
`include "adcoc_defs.svh"
module adcoc_regs
  import adcoc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register access from serial port decoder
  input wire adcoc_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  // Sample path and test state from neighbouring banks
  input wire logic [13:0] sample,
  input wire logic over_range,
  input wire logic test_mode_on,
  input wire logic test_use_pat2,
  input wire logic [7:0] signature_lo,
  input wire logic div_tick,
  input wire logic div_active,
  // Output side controls
  output adcoc_cfg_t cfg,
  output logic [15:0] out_word,
  output logic out_or,
  output logic out_clk_tick,
  output logic [11:0] data_delay_ps,
  output logic [11:0] clock_delay_ps
);

  logic [7:0] trim_r, mode_r, phase_r, dly_r, p1l_r, p1h_r, p2l_r, p2h_r, feat_r;
  logic [7:0] trim_nxt, mode_nxt, phase_nxt, dly_nxt, p1l_nxt, p1h_nxt, p2l_nxt, p2h_nxt, feat_nxt;
  logic [7:0] rdata_nxt;
  logic rvalid_nxt;
  logic [15:0] word_r, word_nxt;
  logic or_r, or_nxt;
  logic tick_raw;

  function automatic logic [11:0] tap_to_ps(input logic [2:0] code);
    tap_to_ps = 12'({9'h000, code} + 12'h001) * 12'(`ADCOC_DELAY_STEP_PS);
  endfunction

  // Register writes; signature offset has no storage so writes fall away
  always_comb begin
    trim_nxt = trim_r;
    mode_nxt = mode_r;
    phase_nxt = phase_r;
    dly_nxt = dly_r;
    p1l_nxt = p1l_r;
    p1h_nxt = p1h_r;
    p2l_nxt = p2l_r;
    p2h_nxt = p2h_r;
    feat_nxt = feat_r;
    if (req.wr) begin
      if (req.addr == `ADCOC_OFF_TRIM) begin
        trim_nxt = req.wdata;
      end else if (req.addr == `ADCOC_OFF_OUT_MODE) begin
        mode_nxt = req.wdata;
      end else if (req.addr == `ADCOC_OFF_CLK_PHASE) begin
        phase_nxt = req.wdata;
      end else if (req.addr == `ADCOC_OFF_FINE_DELAY) begin
        dly_nxt = req.wdata;
      end else if (req.addr == `ADCOC_OFF_PAT1_LO) begin
        p1l_nxt = req.wdata;
      end else if (req.addr == `ADCOC_OFF_PAT1_HI) begin
        p1h_nxt = req.wdata;
      end else if (req.addr == `ADCOC_OFF_PAT2_LO) begin
        p2l_nxt = req.wdata;
      end else if (req.addr == `ADCOC_OFF_PAT2_HI) begin
        p2h_nxt = req.wdata;
      end else if (req.addr == `ADCOC_OFF_FEATURE) begin
        feat_nxt = req.wdata;
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rvalid_nxt = req.rd;
    rdata_nxt = 8'h00;
    if (req.addr == `ADCOC_OFF_TRIM) begin
      rdata_nxt = trim_r;
    end else if (req.addr == `ADCOC_OFF_OUT_MODE) begin
      rdata_nxt = mode_r;
    end else if (req.addr == `ADCOC_OFF_CLK_PHASE) begin
      rdata_nxt = phase_r;
    end else if (req.addr == `ADCOC_OFF_FINE_DELAY) begin
      rdata_nxt = dly_r;
    end else if (req.addr == `ADCOC_OFF_PAT1_LO) begin
      rdata_nxt = p1l_r;
    end else if (req.addr == `ADCOC_OFF_PAT1_HI) begin
      rdata_nxt = p1h_r;
    end else if (req.addr == `ADCOC_OFF_PAT2_LO) begin
      rdata_nxt = p2l_r;
    end else if (req.addr == `ADCOC_OFF_PAT2_HI) begin
      rdata_nxt = p2h_r;
    end else if (req.addr == `ADCOC_OFF_SIG_LO) begin
      rdata_nxt = signature_lo;
    end else if (req.addr == `ADCOC_OFF_FEATURE) begin
      rdata_nxt = feat_r;
    end
    if (!req.rd) begin
      rdata_nxt = 8'h00;
    end
  end

  // Output word: test data overrides converted samples
  always_comb begin
    if (test_mode_on) begin
      word_nxt = test_use_pat2 ? {p2h_r, p2l_r} : {p1h_r, p1l_r};
    end else begin
      word_nxt = {2'h0, sample};
    end
    or_nxt = over_range & feat_r[`ADCOC_BIT_OR_EN];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trim_r <= `ADCOC_RST_ZERO;
      mode_r <= `ADCOC_RST_ZERO;
      phase_r <= `ADCOC_RST_ZERO;
      dly_r <= `ADCOC_RST_ZERO;
      p1l_r <= `ADCOC_RST_ZERO;
      p1h_r <= `ADCOC_RST_ZERO;
      p2l_r <= `ADCOC_RST_ZERO;
      p2h_r <= `ADCOC_RST_ZERO;
      feat_r <= `ADCOC_RST_FEATURE;
      rdata <= 8'h00;
      rvalid <= 1'b0;
      word_r <= 16'h0000;
      or_r <= 1'b0;
    end else begin
      trim_r <= trim_nxt;
      mode_r <= mode_nxt;
      phase_r <= phase_nxt;
      dly_r <= dly_nxt;
      p1l_r <= p1l_nxt;
      p1h_r <= p1h_nxt;
      p2l_r <= p2l_nxt;
      p2h_r <= p2h_nxt;
      feat_r <= feat_nxt;
      rdata <= rdata_nxt;
      rvalid <= rvalid_nxt;
      word_r <= word_nxt;
      or_r <= or_nxt;
    end
  end

  adcoc_phase_sel u_phase (
    .clk(clk),
    .arst_n(arst_n),
    .div_tick(div_tick),
    .div_active(div_active),
    .phase(phase_r[`ADCOC_PHASE_LSB +: 3]),
    .phase_tick(tick_raw)
  );

  // Fine delays are handed to the pad cells; core timing never sees them
  always_comb begin
    cfg.swing_reduced = mode_r[`ADCOC_BIT_SWING];
    cfg.lvds_sel = mode_r[`ADCOC_BIT_OTYPE];
    cfg.dco_invert = phase_r[`ADCOC_BIT_DCO_INV];
    cfg.div_phase = phase_r[`ADCOC_PHASE_LSB +: 3];
    cfg.data_delay = dly_r[`ADCOC_DDLY_LSB +: 3];
    cfg.clock_delay = dly_r[`ADCOC_CDLY_LSB +: 3];
    cfg.or_pin_en = feat_r[`ADCOC_BIT_OR_EN];
    data_delay_ps = tap_to_ps(dly_r[`ADCOC_DDLY_LSB +: 3]);
    clock_delay_ps = tap_to_ps(dly_r[`ADCOC_CDLY_LSB +: 3]);
    out_clk_tick = tick_raw ^ phase_r[`ADCOC_BIT_DCO_INV];
  end

  assign out_word = word_r;
  assign out_or = or_r;

  a_sig_readonly: assert property (@(posedge clk) disable iff (!arst_n)
    req.rd && req.addr == `ADCOC_OFF_SIG_LO |=> rdata == $past(signature_lo))
    else $error("signature read mismatch");
  a_wr_readback: assert property (@(posedge clk) disable iff (!arst_n)
    req.wr && req.addr == `ADCOC_OFF_PAT1_LO ##1 req.rd && !req.wr && req.addr == `ADCOC_OFF_PAT1_LO
    |=> rdata == $past(req.wdata, 2))
    else $error("pattern readback mismatch");
  a_type_follows: assert property (@(posedge clk) disable iff (!arst_n)
    req.wr && req.addr == `ADCOC_OFF_OUT_MODE |=> cfg.lvds_sel == $past(req.wdata[6]))
    else $error("output type not applied");
  a_swing_follows: assert property (@(posedge clk) disable iff (!arst_n)
    req.wr && req.addr == `ADCOC_OFF_OUT_MODE |=> cfg.swing_reduced == $past(req.wdata[7]))
    else $error("swing not applied");
  a_clk_invert: assert property (@(posedge clk) disable iff (!arst_n)
    !div_active |-> out_clk_tick == (div_tick ^ cfg.dco_invert))
    else $error("clock polarity wrong");
  a_phase_delay: assert property (@(posedge clk) disable iff (!arst_n)
    div_active && cfg.div_phase == 3'h2 && $stable(cfg.div_phase) && !cfg.dco_invert
    |-> out_clk_tick == $past(div_tick, 2))
    else $error("phase delay wrong");
  a_delay_ps: assert property (@(posedge clk) disable iff (!arst_n)
    cfg.data_delay == `ADCOC_TAP_MAX |-> data_delay_ps == 12'h910)
    else $error("fine delay range wrong");
  a_pattern_out: assert property (@(posedge clk) disable iff (!arst_n)
    test_mode_on && !test_use_pat2 |=> out_word == $past({p1h_r, p1l_r}))
    else $error("test pattern not driven");
  a_or_gate: assert property (@(posedge clk) disable iff (!arst_n)
    !feat_r[0] |=> !out_or)
    else $error("over-range not gated");
  c_test_mode: cover property (@(posedge clk) disable iff (!arst_n) test_mode_on && test_use_pat2);
  c_lvds: cover property (@(posedge clk) disable iff (!arst_n) cfg.lvds_sel && cfg.swing_reduced);
  c_phase7: cover property (@(posedge clk) disable iff (!arst_n) div_active && cfg.div_phase == 3'h7);
  c_sig_read: cover property (@(posedge clk) disable iff (!arst_n) req.rd && req.addr == `ADCOC_OFF_SIG_LO);

endmodule
`default_nettype wire

/* test/adcoc_rx_model.sv */
// Receiver model that latches output words on the forwarded clock tick
`timescale 1ns/100ps
`default_nettype none
module adcoc_rx_model (
  // Clock and capture inputs
  input wire logic clk,
  input wire logic clk_tick,
  input wire logic [15:0] word,
  // Last captured word
  output logic [15:0] cap
);
  // Takes a word only on a tick, so a missing or misplaced tick shows up as a stale capture
  always_ff @(posedge clk) begin
    if (clk_tick) begin
      cap <= word;
    end
  end
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Self-checking testbench for the output config bank
`timescale 1ns/100ps
`default_nettype none
`include "adcoc_defs.svh"
module tb_top import adcoc_pkg::*;;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  adcoc_req_t req = '0;
  logic [13:0] sample = 14'h0000;
  logic over_range = 1'b0;
  logic test_mode_on = 1'b0;
  logic test_use_pat2 = 1'b0;
  logic [7:0] signature_lo = 8'h00;
  logic div_tick = 1'b0;
  logic div_active = 1'b1;
  logic [7:0] rdata;
  logic rvalid;
  adcoc_cfg_t cfg;
  logic [15:0] out_word;
  logic out_or;
  logic out_clk_tick;
  logic [11:0] data_delay_ps;
  logic [11:0] clock_delay_ps;
  logic [15:0] rx_cap;
  int fails = 0;
  int check_count = 0;

  always #20 clk = ~clk;

  adcoc_regs uut (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
    .sample(sample), .over_range(over_range), .test_mode_on(test_mode_on),
    .test_use_pat2(test_use_pat2), .signature_lo(signature_lo), .div_tick(div_tick),
    .div_active(div_active), .cfg(cfg), .out_word(out_word), .out_or(out_or),
    .out_clk_tick(out_clk_tick), .data_delay_ps(data_delay_ps), .clock_delay_ps(clock_delay_ps));

  adcoc_rx_model rx (.clk(clk), .clk_tick(out_clk_tick), .word(out_word), .cap(rx_cap));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Each call sets the whole request once at a falling edge and leaves it standing;
  // the next call replaces it, so a repeat of the same access in the gap does no harm
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    chk("rvalid", 16'h0001, {15'h0000, rvalid});
    chk("rdata", {8'h00, exp}, {8'h00, rdata});
  endtask

  task automatic t_reset;
    logic [7:0] offs [10] = '{8'h10, 8'h14, 8'h16, 8'h17, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h24, 8'h2a};
    foreach (offs[i]) rd(offs[i], (i == 9) ? `ADCOC_RST_FEATURE : `ADCOC_RST_ZERO);
    rd(8'h30, 8'h00);
    chk("or_pin_en", 16'h0001, {15'h0000, cfg.or_pin_en});
  endtask

  task automatic t_rw;
    wr(`ADCOC_OFF_OUT_MODE, 8'hc0);
    rd(`ADCOC_OFF_OUT_MODE, 8'hc0);
    chk("lvds_sel", 16'h0001, {15'h0000, cfg.lvds_sel});
    chk("swing_reduced", 16'h0001, {15'h0000, cfg.swing_reduced});
    wr(`ADCOC_OFF_OUT_MODE, 8'h80);
    chk("lvds_sel", 16'h0000, {15'h0000, cfg.lvds_sel});
    wr(`ADCOC_OFF_FINE_DELAY, 8'h70);
    chk("data_delay_ps", 16'h0910, {4'h0, data_delay_ps});
    chk("clock_delay_ps", 16'h0122, {4'h0, clock_delay_ps});
    wr(`ADCOC_OFF_FINE_DELAY, 8'h25);
    chk("data_delay_ps", 16'h0366, {4'h0, data_delay_ps});
    chk("clock_delay_ps", 16'h06cc, {4'h0, clock_delay_ps});
    chk("data_delay", 16'h0002, {13'h0000, cfg.data_delay});
    chk("clock_delay", 16'h0005, {13'h0000, cfg.clock_delay});
    wr(`ADCOC_OFF_TRIM, 8'h9c);
    rd(`ADCOC_OFF_TRIM, 8'h9c);
  endtask

  task automatic t_sig;
    signature_lo = 8'h5a;
    wr(`ADCOC_OFF_SIG_LO, 8'hff);
    rd(`ADCOC_OFF_SIG_LO, 8'h5a);
  endtask

  task automatic t_pattern;
    wr(`ADCOC_OFF_PAT1_LO, 8'h34);
    rd(`ADCOC_OFF_PAT1_LO, 8'h34);
    wr(`ADCOC_OFF_PAT1_HI, 8'h12);
    wr(`ADCOC_OFF_PAT2_LO, 8'hcd);
    wr(`ADCOC_OFF_PAT2_HI, 8'hab);
    rd(`ADCOC_OFF_PAT1_HI, 8'h12);
    sample = 14'h2abc;
    @(negedge clk);
    chk("out_word", 16'h2abc, out_word);
    test_mode_on = 1'b1;
    @(negedge clk);
    chk("out_word", 16'h1234, out_word);
    test_use_pat2 = 1'b1;
    div_tick = 1'b1;
    @(negedge clk);
    div_tick = 1'b0;
    chk("out_word", 16'habcd, out_word);
    chk("rx_cap", 16'h1234, rx_cap);
    test_mode_on = 1'b0;
    test_use_pat2 = 1'b0;
  endtask

  task automatic t_or;
    over_range = 1'b1;
    @(negedge clk);
    chk("out_or", 16'h0001, {15'h0000, out_or});
    wr(`ADCOC_OFF_FEATURE, 8'h00);
    @(negedge clk);
    chk("out_or", 16'h0000, {15'h0000, out_or});
    rd(`ADCOC_OFF_FEATURE, 8'h00);
    over_range = 1'b0;
  endtask

  // The tick must show exactly p cycles after the divider tick, inverted when asked
  task automatic t_phase(input logic [2:0] p, input logic inv);
    wr(`ADCOC_OFF_CLK_PHASE, {inv, 4'h0, p});
    chk("dco_invert", {15'h0000, inv}, {15'h0000, cfg.dco_invert});
    chk("div_phase", {13'h0000, p}, {13'h0000, cfg.div_phase});
    repeat (8) @(negedge clk);
    div_tick = 1'b1;
    for (int k = 0; k < 9; k++) begin
      #1;
      chk("out_clk_tick", {15'h0000, (k == p) ^ inv}, {15'h0000, out_clk_tick});
      @(negedge clk);
      div_tick = 1'b0;
    end
  endtask

  // A second reset mid-run must bring back the defaults that earlier scenarios changed
  task automatic t_rst_again;
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    rd(`ADCOC_OFF_FEATURE, `ADCOC_RST_FEATURE);
    rd(`ADCOC_OFF_OUT_MODE, `ADCOC_RST_ZERO);
  endtask

  // Without division the raw tick passes straight through; only the polarity bit still applies
  task automatic t_nodiv;
    wr(`ADCOC_OFF_CLK_PHASE, 8'h83);
    div_active = 1'b0;
    div_tick = 1'b1;
    #1;
    chk("out_clk_tick", 16'h0000, {15'h0000, out_clk_tick});
    @(negedge clk);
    div_tick = 1'b0;
    #1;
    chk("out_clk_tick", 16'h0001, {15'h0000, out_clk_tick});
    repeat (3) @(negedge clk);
    #1;
    chk("out_clk_tick", 16'h0001, {15'h0000, out_clk_tick});
    @(negedge clk);
    div_active = 1'b1;
  endtask

  task automatic end_of_test;
    $display("Checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_rw();
    t_sig();
    t_pattern();
    t_or();
    t_rst_again();
    t_phase(3'h0, 1'b0);
    t_phase(3'h3, 1'b1);
    t_phase(3'h7, 1'b0);
    t_nodiv();
    end_of_test();
  end

  // Whole run needs about a hundred cycles; this limit leaves ample margin
  initial begin
    #100000;
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
